// *** common/hbad_pkg.sv ***
/*
  Decoder package: register offsets, control field
  positions, reset values, route codes and address boundaries.
  Assumes a 44-bit processor address and 4 KB window bounds.
*/
`default_nettype none
package hbad_pkg;
  // address widths
  localparam int ADDR_W = 44; // processor side address width
  localparam int DMA_W = 32; // I/O bus memory space address width
  localparam int PAGE_W = 32; // window bounds are held as 4 KB page numbers
  localparam int REG_AW = 8; // avalon byte address width

  // register byte offsets
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] OFS_MASK = 8'h08;
  localparam logic [REG_AW-1:0] OFS_CTL_AREA_BASE = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_PIO_BASE = 8'h10;
  localparam logic [REG_AW-1:0] OFS_PIO_TOP = 8'h14;
  localparam logic [REG_AW-1:0] OFS_PMEM_BASE = 8'h18;
  localparam logic [REG_AW-1:0] OFS_PMEM_TOP = 8'h1c;
  localparam logic [REG_AW-1:0] OFS_FIRST_SM_TOP = 8'h20;
  localparam logic [REG_AW-1:0] OFS_SM_WIN = 8'h40; // base, top pairs, 8 bytes apart

  // control register fields
  localparam int CTRL_W = 8;
  localparam int CB_PROC_HOLE = 0;
  localparam int CB_IO_HOLE = 1;
  localparam int CB_PERIPH_ALIAS = 2;
  localparam int CB_SYSMEM_ALIAS = 3;
  localparam int CB_DISCONTIG = 4;
  localparam int CB_ADDR64 = 5;
  localparam int CB_FWD_RSVD_IO = 6;
  localparam int CB_DMA_CTL_FWD = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00; // every mode off at reset

  // status / mask fields
  localparam int ST_W = 3;
  localparam int SB_CPU_UNDEF = 0;
  localparam int SB_DMA_PIO = 1;
  localparam int SB_CPU_RSVD_IO = 2;

  // window bound reset values (page numbers)
  localparam logic [PAGE_W-1:0] PAGE_RESET = 32'h0000_0000;

  // fixed boundaries
  localparam logic [ADDR_W-1:0] A_4GB = 44'h001_0000_0000;
  localparam logic [ADDR_W-1:0] A_640K = 44'h000_000a_0000;
  localparam logic [ADDR_W-1:0] A_768K = 44'h000_000c_0000;
  localparam logic [DMA_W-1:0] D_640K = 32'h000a_0000;
  localparam logic [DMA_W-1:0] D_1M = 32'h0010_0000;
  localparam logic [ADDR_W-1:0] ALIAS_SPAN_M1 = 44'h000_00ff_ffff; // 16 MB - 1
  localparam logic [DMA_W-1:0] D_ALIAS_SPAN_M1 = 32'h00ff_ffff;
  localparam logic [DMA_W-1:0] IO_64K = 32'h0001_0000;
  localparam logic [DMA_W-1:0] IO_8M = 32'h0080_0000;
  localparam logic [11:0] PAGE_LOW = 12'h000;
  localparam logic [11:0] PAGE_HIGH = 12'hfff;

  // processor access routes
  typedef enum logic [2:0] {
    HBAD_RT_ROM,
    HBAD_RT_SYSMEM,
    HBAD_RT_IO_MEM,
    HBAD_RT_IO_SPACE,
    HBAD_RT_RSVD,
    HBAD_RT_UNDEF
  } hbad_route_t;
endpackage
`default_nettype wire

// *** design/hbad_decoder.sv ***
/*
  Decoder top: routes and translates processor loads and
  stores, decides inbound DMA response and translation, holds
  configuration, status and mask registers behind an Avalon-MM slave.
  Assumes requests synchronous to clk_sys_i, one per cycle
  per path; results one clock after the request.
*/
`default_nettype none
module hbad_decoder
  import hbad_pkg::*;
#(
  parameter int N_SM = 2, // additional system memory windows
  parameter bit IS_PRIMARY = 1'b1 // this is the primary_bridge
) (
  input wire logic clk_sys_i, // bridge clock
  input wire logic nrst_i, // asynchronous reset, active low
  // avalon-mm register slave
  input wire logic [REG_AW-1:0] avs_address_i, // byte address
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o, // level, unmasked status pending
  // processor load/store decode
  input wire logic cpu_req_i, // one-cycle request
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  output logic cpu_valid_o, // one-cycle result strobe
  output logic [2:0] cpu_route_o, // hbad_route_t code
  output logic [ADDR_W-1:0] cpu_addr_o, // translated address
  // inbound DMA decode
  input wire logic dma_req_i, // one-cycle request
  input wire logic dma_io_space_i, // request targets I/O space, not memory
  input wire logic [DMA_W-1:0] dma_addr_i,
  output logic dma_valid_o, // one-cycle result strobe
  output logic dma_respond_o, // bridge claims the access
  output logic dma_error_o, // claimed and signalled as error
  output logic dma_xlate_o, // address goes on to translation_entry lookup
  output logic [DMA_W-1:0] dma_addr_o // pre-translated address
);
  // configuration and state registers
  logic [CTRL_W-1:0] ctrl_reg; // mode enables
  logic [ST_W-1:0] status_reg; // sticky events
  logic [ST_W-1:0] status_next;
  logic [ST_W-1:0] mask_reg; // interrupt mask
  logic [PAGE_W-1:0] ctl_area_base_reg;
  logic [PAGE_W-1:0] pio_base_reg;
  logic [PAGE_W-1:0] pio_top_reg;
  logic [PAGE_W-1:0] pmem_base_reg;
  logic [PAGE_W-1:0] pmem_top_reg;
  logic [PAGE_W-1:0] first_sm_top_reg;
  logic [PAGE_W-1:0] sm_base_reg [N_SM];
  logic [PAGE_W-1:0] sm_top_reg [N_SM];
  // bus handshake
  logic wait_reg; // waitrequest
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic bus_done; // request completes on this edge
  logic [31:0] rd_mux; // read data for current address
  logic [31:0] wmask; // byte enables as bit mask
  // decode events
  logic ev_cpu_undef;
  logic ev_cpu_rsvd;
  logic ev_dma_pio;

  // full-width bounds, rebuilt from page registers each decode
  logic [ADDR_W-1:0] cab_a;
  logic [ADDR_W-1:0] pio_base_a;
  logic [ADDR_W-1:0] pio_top_a;
  logic [ADDR_W-1:0] pm_base_a;
  logic [ADDR_W-1:0] pm_top_a;
  logic [ADDR_W-1:0] alias_base_a; // alias_window_base
  logic [ADDR_W-1:0] sm0_top_a;
  assign cab_a = {ctl_area_base_reg, PAGE_LOW};
  assign pio_base_a = {pio_base_reg, PAGE_LOW};
  assign pio_top_a = {pio_top_reg, PAGE_HIGH};
  assign pm_base_a = {pmem_base_reg, PAGE_LOW};
  assign pm_top_a = {pmem_top_reg, PAGE_HIGH};
  assign alias_base_a = pm_top_a - ALIAS_SPAN_M1;
  assign sm0_top_a = {first_sm_top_reg, PAGE_HIGH};

  // mode enables; the primary-only features are forced off here when IS_PRIMARY is clear
  logic proc_hole_en;
  logic io_hole_en;
  logic periph_alias_en;
  logic sysmem_alias_en;
  assign proc_hole_en = IS_PRIMARY && ctrl_reg[CB_PROC_HOLE];
  assign io_hole_en = IS_PRIMARY && ctrl_reg[CB_IO_HOLE];
  assign periph_alias_en = IS_PRIMARY && ctrl_reg[CB_PERIPH_ALIAS];
  assign sysmem_alias_en = IS_PRIMARY && ctrl_reg[CB_SYSMEM_ALIAS];

  // processor-side window hits
  logic [N_SM-1:0] sm_hit; // one bit per additional memory window
  logic cpu_in_ctl;
  logic cpu_in_pio;
  logic cpu_in_pm;
  logic cpu_in_alias;
  logic cpu_in_sm0;
  logic cpu_in_hole;
  assign cpu_in_ctl = cpu_addr_i >= cab_a && cpu_addr_i < A_4GB;
  assign cpu_in_pio = cpu_addr_i >= pio_base_a && cpu_addr_i <= pio_top_a;
  assign cpu_in_pm = cpu_addr_i >= pm_base_a && cpu_addr_i <= pm_top_a;
  assign cpu_in_alias = cpu_addr_i >= alias_base_a && cpu_addr_i <= pm_top_a;
  assign cpu_in_sm0 = cpu_addr_i <= sm0_top_a;
  assign cpu_in_hole = cpu_addr_i >= A_640K && cpu_addr_i < A_768K;

  // one comparator pair per additional system memory window
  genvar gi;
  generate
    for (gi = 0; gi < N_SM; gi++) begin : g_sm
      assign sm_hit[gi] = cpu_addr_i >= {sm_base_reg[gi], PAGE_LOW} &&
                          cpu_addr_i <= {sm_top_reg[gi], PAGE_HIGH};
    end
  endgenerate

  // peripheral I/O translation for processor accesses
  logic [ADDR_W-1:0] pio_off_a;
  logic [DMA_W-1:0] pio_io_addr;
  logic pio_rsvd;
  assign pio_off_a = cpu_addr_i - pio_base_a;

  hbad_pio_xlate u_pio (
    .offset_i(pio_off_a[DMA_W-1:0]),
    .discontig_i(ctrl_reg[CB_DISCONTIG]),
    .fwd_rsvd_i(ctrl_reg[CB_FWD_RSVD_IO]),
    .io_addr_o(pio_io_addr),
    .reserved_o(pio_rsvd)
  );

  // processor route selection, first match wins
  hbad_route_t cpu_route;
  logic [ADDR_W-1:0] cpu_xaddr;
  logic [ADDR_W-1:0] alias_off_a;
  assign alias_off_a = cpu_addr_i - alias_base_a;
  always_comb begin
    cpu_route = HBAD_RT_UNDEF;
    cpu_xaddr = cpu_addr_i;
    if (cpu_in_ctl) begin
      // rom controller, passed on untranslated here
      cpu_route = HBAD_RT_ROM;
    end else if (cpu_in_pio) begin
      // peripheral I/O window, translated to I/O space
      cpu_route = pio_rsvd ? HBAD_RT_RSVD : HBAD_RT_IO_SPACE;
      cpu_xaddr = {{(ADDR_W-DMA_W){1'b0}}, pio_io_addr};
    end else if (cpu_in_pm) begin
      // peripheral memory, alias top 16 MB folds to zero when enabled
      cpu_route = HBAD_RT_IO_MEM;
      if (periph_alias_en && cpu_in_alias) begin
        cpu_xaddr = {20'h00000, alias_off_a[23:0]};
      end
    end else if (|sm_hit) begin
      // additional system memory, no translation
      cpu_route = HBAD_RT_SYSMEM;
    end else if (cpu_in_sm0) begin
      // low memory, hole goes to the I/O bus when enabled
      cpu_route = (proc_hole_en && cpu_in_hole) ? HBAD_RT_IO_MEM : HBAD_RT_SYSMEM;
    end else begin
      // undefined space, reported through status
      cpu_route = HBAD_RT_UNDEF;
    end
  end

  // processor result registers
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_valid_o <= 1'b0;
      cpu_route_o <= 3'h0;
      cpu_addr_o <= '0;
    end else begin
      cpu_valid_o <= cpu_req_i;
      if (cpu_req_i) begin
        cpu_route_o <= cpu_route;
        cpu_addr_o <= cpu_xaddr;
      end
    end
  end

  assign ev_cpu_undef = cpu_req_i && cpu_route == HBAD_RT_UNDEF;
  assign ev_cpu_rsvd = cpu_req_i && cpu_route == HBAD_RT_RSVD;

  // dma-side window hits; only the low 32 bits exist on the I/O bus
  logic [DMA_W-1:0] d_pio_base;
  logic [DMA_W-1:0] d_pio_top;
  logic [DMA_W-1:0] d_pm_base;
  logic [DMA_W-1:0] d_pm_top;
  logic [DMA_W-1:0] d_alias_base;
  logic [DMA_W-1:0] d_alias_off;
  logic d_ctl_valid; // control area base lies below 4 GB
  logic [DMA_W-1:0] d_cab;
  assign d_pio_base = pio_base_a[DMA_W-1:0];
  assign d_pio_top = pio_top_a[DMA_W-1:0];
  assign d_pm_base = pm_base_a[DMA_W-1:0];
  assign d_pm_top = pm_top_a[DMA_W-1:0];
  assign d_alias_base = d_pm_top - D_ALIAS_SPAN_M1;
  assign d_alias_off = dma_addr_i - d_alias_base;
  assign d_ctl_valid = cab_a < A_4GB;
  assign d_cab = cab_a[DMA_W-1:0];

  // dma response decision, first match wins
  logic d_resp;
  logic d_err;
  logic d_fwd; // claimed and forwarded to the host side
  logic [DMA_W-1:0] d_xaddr;
  always_comb begin
    d_resp = 1'b1;
    d_err = 1'b0;
    d_fwd = 1'b1;
    d_xaddr = dma_addr_i;
    if (dma_io_space_i) begin
      // the bridge is never an I/O space target
      d_resp = 1'b0;
      d_fwd = 1'b0;
    end else if (dma_addr_i >= d_pio_base && dma_addr_i <= d_pio_top) begin
      // own peripheral I/O window: claim and signal error
      d_err = 1'b1;
      d_fwd = 1'b0;
    end else if (dma_addr_i >= d_pm_base && dma_addr_i <= d_pm_top) begin
      if (sysmem_alias_en && dma_addr_i >= d_alias_base) begin
        // alias window folds onto 0 .. 16 MB - 1
        d_xaddr = {8'h00, d_alias_off[23:0]};
      end else begin
        // device to device transfer, left to the target
        d_resp = 1'b0;
        d_fwd = 1'b0;
      end
    end else if (IS_PRIMARY && dma_addr_i >= D_640K && dma_addr_i < D_1M) begin
      // legacy range follows the io-hole
      d_resp = !io_hole_en;
      d_fwd = !io_hole_en;
    end else if (d_ctl_valid && dma_addr_i >= d_cab) begin
      // control area: forwarding is a software choice
      d_resp = ctrl_reg[CB_DMA_CTL_FWD];
      d_fwd = ctrl_reg[CB_DMA_CTL_FWD];
    end else begin
      // everything else passes untranslated
      d_resp = 1'b1;
    end
  end

  // dma result registers
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dma_valid_o <= 1'b0;
      dma_respond_o <= 1'b0;
      dma_error_o <= 1'b0;
      dma_xlate_o <= 1'b0;
      dma_addr_o <= '0;
    end else begin
      dma_valid_o <= dma_req_i;
      if (dma_req_i) begin
        dma_respond_o <= d_resp;
        dma_error_o <= d_err;
        // forwarded addresses take the entry table when enabled
        dma_xlate_o <= d_fwd && ctrl_reg[CB_ADDR64];
        dma_addr_o <= d_xaddr;
      end
    end
  end

  assign ev_dma_pio = dma_req_i && d_err;

  // avalon slave: waitrequest drops for one cycle per request
  assign bus_done = (avs_read_i || avs_write_i) && !wait_reg;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign wmask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
    end
  endgenerate

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_i)
      OFS_CTRL: rd_mux = {24'h000000, ctrl_reg};
      OFS_STATUS: rd_mux = {29'h0000_0000, status_reg};
      OFS_MASK: rd_mux = {29'h0000_0000, mask_reg};
      OFS_CTL_AREA_BASE: rd_mux = ctl_area_base_reg;
      OFS_PIO_BASE: rd_mux = pio_base_reg;
      OFS_PIO_TOP: rd_mux = pio_top_reg;
      OFS_PMEM_BASE: rd_mux = pmem_base_reg;
      OFS_PMEM_TOP: rd_mux = pmem_top_reg;
      OFS_FIRST_SM_TOP: rd_mux = first_sm_top_reg;
      default: begin
        for (int i = 0; i < N_SM; i++) begin
          if (avs_address_i == OFS_SM_WIN + REG_AW'(8 * i)) begin
            rd_mux = sm_base_reg[i];
          end
          if (avs_address_i == OFS_SM_WIN + REG_AW'(8 * i + 4)) begin
            rd_mux = sm_top_reg[i];
          end
        end
      end
    endcase
  end

  // handshake and read data; the slave answers on the second edge
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !((avs_read_i || avs_write_i) && wait_reg);
      if (avs_read_i && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // control and mask writes; modes reset to off
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= '0;
    end else if (bus_done && avs_write_i) begin
      if (avs_address_i == OFS_CTRL) begin
        ctrl_reg <= (ctrl_reg & ~wmask[CTRL_W-1:0]) | (avs_writedata_i[CTRL_W-1:0] &
                    wmask[CTRL_W-1:0]);
      end
      if (avs_address_i == OFS_MASK) begin
        mask_reg <= (mask_reg & ~wmask[ST_W-1:0]) | (avs_writedata_i[ST_W-1:0] &
                    wmask[ST_W-1:0]);
      end
    end
  end

  // window bound writes, byte-lane merged
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_area_base_reg <= PAGE_RESET;
      pio_base_reg <= PAGE_RESET;
      pio_top_reg <= PAGE_RESET;
      pmem_base_reg <= PAGE_RESET;
      pmem_top_reg <= PAGE_RESET;
      first_sm_top_reg <= PAGE_RESET;
      for (int i = 0; i < N_SM; i++) begin
        sm_base_reg[i] <= PAGE_RESET;
        sm_top_reg[i] <= PAGE_RESET;
      end
    end else if (bus_done && avs_write_i) begin
      unique case (avs_address_i)
        OFS_CTL_AREA_BASE: ctl_area_base_reg <= merge(ctl_area_base_reg);
        OFS_PIO_BASE: pio_base_reg <= merge(pio_base_reg);
        OFS_PIO_TOP: pio_top_reg <= merge(pio_top_reg);
        OFS_PMEM_BASE: pmem_base_reg <= merge(pmem_base_reg);
        OFS_PMEM_TOP: pmem_top_reg <= merge(pmem_top_reg);
        OFS_FIRST_SM_TOP: first_sm_top_reg <= merge(first_sm_top_reg);
        default: begin
          for (int i = 0; i < N_SM; i++) begin
            if (avs_address_i == OFS_SM_WIN + REG_AW'(8 * i)) begin
              sm_base_reg[i] <= merge(sm_base_reg[i]);
            end
            if (avs_address_i == OFS_SM_WIN + REG_AW'(8 * i + 4)) begin
              sm_top_reg[i] <= merge(sm_top_reg[i]);
            end
          end
        end
      endcase
    end
  end

  // byte-enable merge of write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | (avs_writedata_i & wmask);
  endfunction

  // sticky status: a same-cycle event beats the read-clear
  always_comb begin
    status_next = status_reg;
    if (bus_done && avs_read_i && avs_address_i == OFS_STATUS) begin
      status_next = '0;
    end
    status_next[SB_CPU_UNDEF] = status_next[SB_CPU_UNDEF] | ev_cpu_undef;
    status_next[SB_DMA_PIO] = status_next[SB_DMA_PIO] | ev_dma_pio;
    status_next[SB_CPU_RSVD_IO] = status_next[SB_CPU_RSVD_IO] | ev_cpu_rsvd;
  end

  // status and interrupt level
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign irq_o = irq_reg;
endmodule
`default_nettype wire

// *** design/hbad_pio_xlate.sv ***
/*
  Peripheral I/O window translation: turns a window offset
  into an I/O bus I/O space address.
  Assumes the offset lies inside the window.
*/
`default_nettype none
module hbad_pio_xlate
  import hbad_pkg::*;
(
  input wire logic [DMA_W-1:0] offset_i, // offset from periph_io_base
  input wire logic discontig_i, // discontiguous mode enable
  input wire logic fwd_rsvd_i, // pass the reserved band through
  output logic [DMA_W-1:0] io_addr_o, // I/O space address
  output logic reserved_o // offset hits the reserved band outside discontiguous mode while fwd_rsvd_i is clear
);
  // pure decode; the parent registers the result
  always_comb begin
    io_addr_o = offset_i;
    reserved_o = 1'b0;
    if (discontig_i && offset_i < IO_8M) begin
      // page number picks the 32-byte block, the top 7 offset bits are dropped
      io_addr_o = {16'h0000, offset_i[22:12], offset_i[4:0]};
    end else if (!discontig_i && offset_i >= IO_64K && offset_i < IO_8M) begin
      // reserved band: forwarded 1:1 only when software allows it
      reserved_o = !fwd_rsvd_i;
    end else begin
      // 8 MB upward, and the low 64 KB outside discontiguous mode, map one to one
      io_addr_o = offset_i;
    end
  end
endmodule
`default_nettype wire

// *** testbench/hbad_decoder_checker.sv ***
/* port checker of the address decoder
   assumes one clock domain, attached by bind from the bench top */
`default_nettype none
module hbad_decoder_checker
  import hbad_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic cpu_req_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic cpu_valid_o,
  input wire logic [2:0] cpu_route_o,
  input wire logic [ADDR_W-1:0] cpu_addr_o,
  input wire logic dma_req_i,
  input wire logic dma_io_space_i,
  input wire logic dma_valid_o,
  input wire logic dma_respond_o,
  input wire logic dma_error_o,
  input wire logic dma_xlate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // a request and its strobe one edge later
  sequence s_cpu_take; cpu_req_i ##1 cpu_valid_o; endsequence
  // one cycle of ready, then busy again
  sequence s_bus_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  property p_cpu_lat; cpu_req_i |-> s_cpu_take; endproperty
  a_cpu_lat: assert property (p_cpu_lat) else $error("cpu result late");
  property p_cpu_idle; !cpu_req_i |=> !cpu_valid_o; endproperty
  a_cpu_idle: assert property (p_cpu_idle) else $error("cpu strobe unasked");
  property p_dma_lat; dma_req_i |=> dma_valid_o; endproperty
  a_dma_lat: assert property (p_dma_lat) else $error("dma result late");
  property p_io_space; dma_req_i && dma_io_space_i |=> !dma_respond_o && !dma_xlate_o; endproperty
  a_io_space: assert property (p_io_space) else $error("claimed io space");
  property p_err_claim; dma_valid_o && dma_error_o |-> dma_respond_o && !dma_xlate_o; endproperty
  a_err_claim: assert property (p_err_claim) else $error("error not claimed");
  property p_sys_flat;
    cpu_valid_o && cpu_route_o == HBAD_RT_SYSMEM |-> cpu_addr_o == $past(cpu_addr_i);
  endproperty
  a_sys_flat: assert property (p_sys_flat) else $error("sysmem translated");
  property p_rom_flat;
    cpu_valid_o && cpu_route_o == HBAD_RT_ROM |-> cpu_addr_o == $past(cpu_addr_i);
  endproperty
  a_rom_flat: assert property (p_rom_flat) else $error("rom translated");
  property p_addr_hold; !cpu_req_i |=> $stable(cpu_addr_o) && $stable(cpu_route_o); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("cpu result moved");
  property p_route_code; cpu_valid_o |-> cpu_route_o <= 3'h5; endproperty
  a_route_code: assert property (p_route_code) else $error("bad route code");
  property p_bus_ack; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_bus_ack; endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer off");
endmodule
`default_nettype wire

// *** testbench/hbad_decoder_tb_top.sv ***
/* decoder bench: table driven decode checks
   assumes the far model requests, checker bound below */
`default_nettype none
module hbad_decoder_tb_top
  import hbad_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, avs_read, avs_write, avs_wait, irq, cpu_req, cpu_valid;
  logic dma_req, dma_io, dma_valid, dma_resp, dma_err, dma_xl;
  logic [REG_AW-1:0] avs_address;
  logic [31:0] avs_wdata, avs_rdata, ra;
  logic [ADDR_W-1:0] cpu_addr, cpu_xaddr;
  logic [2:0] cpu_route;
  logic [DMA_W-1:0] dma_addr, dma_xaddr;
  logic [46:0] cq[$]; // route, address
  logic [34:0] dq[$]; // respond, error, xlate, address
  logic [31:0] rq[$]; // read data
  int err_total = 0, tests_run = 0, cycles = 0, i;
  hbad_decoder dut (.clk_sys_i(clk), .nrst_i(nrst), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait),
    .irq_o(irq), .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr), .cpu_valid_o(cpu_valid),
    .cpu_route_o(cpu_route), .cpu_addr_o(cpu_xaddr), .dma_req_i(dma_req),
    .dma_io_space_i(dma_io), .dma_addr_i(dma_addr), .dma_valid_o(dma_valid),
    .dma_respond_o(dma_resp), .dma_error_o(dma_err), .dma_xlate_o(dma_xl),
    .dma_addr_o(dma_xaddr));
  hbad_far_model far (.clk_i(clk), .cpu_req_o(cpu_req), .cpu_addr_o(cpu_addr),
    .dma_req_o(dma_req), .dma_io_o(dma_io), .dma_addr_o(dma_addr));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic bad(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task stop_test();
    $display("counts: %0d compared, %0d unexpected", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // write (w high) or read; held until waitrequest is sampled low, bounded
  task automatic rw(input logic w, input logic [REG_AW-1:0] a, input logic [31:0] d);
    int n = 0;
    if (!w) rq.push_back(d);
    @(posedge clk);
    {avs_write, avs_read, avs_address, avs_wdata} <= {w, !w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 50);
    if (n >= 50) bad("no bus answer");
    {avs_write, avs_read} <= 2'b00;
  endtask
  task cpu_chk(input logic [7:0] c, input logic [ADDR_W-1:0] a,
      input logic [2:0] r, input logic [ADDR_W-1:0] x);
    rw(1'b1, OFS_CTRL, {24'h0, c});
    cq.push_back({r, x});
    far.cpu_op(a);
  endtask
  task dma_chk(input logic [7:0] c, input logic io, input logic [DMA_W-1:0] a,
      input logic [2:0] f, input logic [DMA_W-1:0] x);
    rw(1'b1, OFS_CTRL, {24'h0, c});
    dq.push_back({f, x});
    far.dma_op(io, a);
  endtask
  // address compared only where routed
  task cmp_cpu(input logic [46:0] e);
    tests_run++;
    if (cpu_route !== e[46:44] || (e[46:44] < 3'h4 && cpu_xaddr !== e[43:0]))
      bad("cpu decode");
  endtask
  task cmp_dma(input logic [34:0] e);
    tests_run++;
    if ({dma_resp, dma_err, dma_xl} !== e[34:32] || (e[34:33] == 2'b10 && dma_xaddr !== e[31:0]))
      bad("dma decode");
  endtask
  task cmp_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) bad("irq level");
  endtask
  // takes the oldest note whenever a result shows
  always @(posedge clk) begin
    if (cpu_valid === 1'b1) begin
      if (cq.size() == 0) bad("stray cpu result");
      else cmp_cpu(cq.pop_front());
    end
    if (dma_valid === 1'b1) begin
      if (dq.size() == 0) bad("stray dma result");
      else cmp_dma(dq.pop_front());
    end
    if (avs_read === 1'b1 && avs_wait === 1'b0) begin
      tests_run++;
      if (rq.size() == 0 || avs_rdata !== rq.pop_front()) bad("read data");
    end
  end
  // a few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad("timeout");
      stop_test();
    end
  end
  initial begin
    {nrst, avs_address, avs_read, avs_write, avs_wdata} = '0;
    ra = $urandom(32'he42b1520);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rw(1'b0, OFS_CTRL, 32'h0);
    rw(1'b0, OFS_STATUS, 32'h0);
    rw(1'b0, OFS_MASK, 32'h0);
    rw(1'b0, 8'hfc, 32'h0);
    $display("test reset values done");
    rw(1'b1, OFS_CTL_AREA_BASE, 32'hff000);
    rw(1'b1, OFS_PIO_BASE, 32'h80000);
    rw(1'b1, OFS_PIO_TOP, 32'h80fff);
    rw(1'b1, OFS_PMEM_BASE, 32'hc0000);
    rw(1'b1, OFS_PMEM_TOP, 32'hc0fff);
    rw(1'b1, OFS_FIRST_SM_TOP, 32'hfff);
    rw(1'b1, OFS_SM_WIN, 32'h100000);
    rw(1'b1, OFS_SM_WIN + 8'h04, 32'h1000ff);
    rw(1'b0, OFS_PIO_TOP, 32'h80fff);
    cpu_chk(8'h00, 44'hff00_1234, HBAD_RT_ROM, 44'hff00_1234);
    cpu_chk(8'h00, 44'hc000_1000, HBAD_RT_IO_MEM, 44'hc000_1000);
    cpu_chk(8'h04, 44'hc000_1000, HBAD_RT_IO_MEM, 44'h1000);
    cpu_chk(8'h00, 44'h1_0000_0080, HBAD_RT_SYSMEM, 44'h1_0000_0080);
    cpu_chk(8'h01, 44'ha_1000, HBAD_RT_IO_MEM, 44'ha_1000);
    cpu_chk(8'h01, 44'hc_0000, HBAD_RT_SYSMEM, 44'hc_0000);
    cpu_chk(8'h00, 44'h5000_0000, HBAD_RT_UNDEF, 44'h0);
    cpu_chk(8'h00, 44'h8000_1234, HBAD_RT_IO_SPACE, 44'h1234);
    cpu_chk(8'h00, 44'h8081_2345, HBAD_RT_IO_SPACE, 44'h81_2345);
    cpu_chk(8'h00, 44'h8002_0000, HBAD_RT_RSVD, 44'h0);
    cpu_chk(8'h40, 44'h8002_0000, HBAD_RT_IO_SPACE, 44'h2_0000);
    cpu_chk(8'h10, 44'h8000_3fe5, HBAD_RT_IO_SPACE, 44'h65);
    cpu_chk(8'h10, 44'h8000_3005, HBAD_RT_IO_SPACE, 44'h65);
    for (i = 0; i < 8; i++) begin
      ra = $urandom_range(32'h9ffff);
      cpu_chk(8'h01, {12'h0, ra}, HBAD_RT_SYSMEM, {12'h0, ra});
    end
    $display("test cpu decode done");
    repeat (3) @(posedge clk);
    cmp_bit(irq, 1'b0);
    rw(1'b1, OFS_MASK, 32'h1);
    repeat (3) @(posedge clk);
    cmp_bit(irq, 1'b1);
    rw(1'b0, OFS_STATUS, 32'h5);
    rw(1'b0, OFS_STATUS, 32'h0);
    cmp_bit(irq, 1'b0);
    $display("test interrupt done");
    dma_chk(8'h00, 1'b1, 32'h1000, 3'b000, 32'h0);
    dma_chk(8'h00, 1'b0, 32'h80001000, 3'b110, 32'h0);
    dma_chk(8'h00, 1'b0, 32'hc0001000, 3'b000, 32'h0);
    dma_chk(8'h08, 1'b0, 32'hc0001000, 3'b100, 32'h1000);
    dma_chk(8'h00, 1'b0, 32'ha8000, 3'b100, 32'ha8000);
    dma_chk(8'h02, 1'b0, 32'hffff0, 3'b000, 32'h0);
    dma_chk(8'h00, 1'b0, 32'hff000010, 3'b000, 32'h0);
    dma_chk(8'h80, 1'b0, 32'hff000010, 3'b100, 32'hff000010);
    dma_chk(8'h00, 1'b0, 32'h20000000, 3'b100, 32'h20000000);
    dma_chk(8'h20, 1'b0, 32'h20000000, 3'b101, 32'h20000000);
    dma_chk(8'h28, 1'b0, 32'hc0001000, 3'b101, 32'h1000);
    rw(1'b0, OFS_STATUS, 32'h2);
    repeat (4) @(posedge clk);
    tests_run++;
    if (cq.size() + dq.size() + rq.size() != 0) bad("results missing");
    $display("test dma decode done");
    stop_test();
  end
endmodule
bind hbad_decoder hbad_decoder_checker u_chk (.*);
`default_nettype wire

// *** testbench/hbad_far_model.sv ***
/* far side: a processor master and an I/O bus device
   assumes one task call at a time */
`default_nettype none
module hbad_far_model
  import hbad_pkg::*;
(
  input wire logic clk_i,
  output logic cpu_req_o,
  output logic [ADDR_W-1:0] cpu_addr_o,
  output logic dma_req_o,
  output logic dma_io_o,
  output logic [DMA_W-1:0] dma_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet at time zero
  initial {cpu_req_o, cpu_addr_o, dma_req_o, dma_io_o, dma_addr_o} = '0;
  // one-cycle op; address inverted after so stale values never match
  task cpu_op(input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    cpu_req_o <= 1'b1;
    cpu_addr_o <= a;
    @(posedge clk_i);
    cpu_req_o <= 1'b0;
    cpu_addr_o <= ~a;
  endtask
  // one-cycle inbound cycle, memory or io space
  task dma_op(input logic io, input logic [DMA_W-1:0] a);
    @(posedge clk_i);
    dma_req_o <= 1'b1;
    dma_io_o <= io;
    dma_addr_o <= a;
    @(posedge clk_i);
    dma_req_o <= 1'b0;
    dma_io_o <= ~io;
    dma_addr_o <= ~a;
  endtask
endmodule
`default_nettype wire
